//--- verif/lfm_fault_manager_assertions.sv
// Checker for the LED driver fault manager, bound to its top module.
// Assumes one system clock and the design's synchronous active-low reset.
`timescale 1ns/1ps

module lfm_fault_manager_assertions #(
    parameter NUM_CH         = 6,
    parameter STEP_CYCLES    = 20,
    parameter HOT_TMO_CYCLES = 10
)(
    // Clock and reset.
    input wire              i_sys_clk,
    input wire              i_rst_n,
    // Watched inputs.
    input wire              i_fet_fully_on,
    input wire              i_input_undervoltage_lockout,
    input wire              i_switch_over_limit,
    input wire              i_input_overcurrent,
    input wire              i_ovp_above_collapse,
    input wire              i_reg_rd,
    input wire [7:0]        i_reg_addr,
    // Watched outputs.
    input wire [7:0]        o_reg_rdata,
    input wire              o_boost_run,
    input wire              o_switch_on,
    input wire [3:0]        o_current_limit,
    input wire              o_fet_gate_off,
    input wire [NUM_CH-1:0] o_channel_enable
);
    default clocking cb @(posedge i_sys_clk); endclocking
    default disable iff (!i_rst_n);

    reg [3:0]  prev_limit;
    reg [31:0] step_gap;

    // Counts cycles since the current limit last moved, to bound the ramp rate.
    always @(posedge i_sys_clk)
    begin
        prev_limit <= o_current_limit;
        if (!i_rst_n || (o_current_limit != prev_limit))
            step_gap <= 32'h0;
        else
            step_gap <= step_gap + 32'h1;
    end

    sequence over_held;
        i_switch_over_limit [*3];
    endsequence
    sequence ovc_held;
        i_input_overcurrent [*3];
    endsequence
    sequence input_undervoltage_lockout_held;
        i_input_undervoltage_lockout [*3];
    endsequence

    boost_gate_a: assert property ($rose(o_boost_run) |-> $past(i_fet_fully_on, 3))
        else $error("boost started without the protection FET on");
    limit_start_a: assert property ($rose(o_boost_run) |-> o_current_limit == 4'h1)
        else $error("soft-start did not begin at the lowest limit");
    limit_step_a: assert property ((o_current_limit != prev_limit) && (o_current_limit != 4'h1)
        |-> o_current_limit == prev_limit + 4'h1)
        else $error("current limit moved by other than one step");
    limit_range_a: assert property (o_current_limit >= 4'h1 && o_current_limit <= 4'h8)
        else $error("current limit out of range");
    step_gap_a: assert property ((o_current_limit != prev_limit) && (o_current_limit != 4'h1)
        |-> step_gap >= STEP_CYCLES - 1)
        else $error("soft-start step came too early");
    switch_cut_a: assert property (over_held |=> !o_switch_on)
        else $error("switch stayed on above the current limit");
    ovc_shut_a: assert property (ovc_held |=> ~|o_channel_enable)
        else $error("channels stayed on after input overcurrent");
    collapse_cause_a: assert property ($rose(o_fet_gate_off)
        |-> $past(i_ovp_above_collapse, 3) == 1'b0)
        else $error("FET switched off without a sense collapse");
    fet_hold_a: assert property (o_fet_gate_off |=> o_fet_gate_off)
        else $error("FET off command released");
    input_undervoltage_lockout_stop_a: assert property (input_undervoltage_lockout_held |=> !o_boost_run && o_current_limit == 4'h1)
        else $error("switching went on during undervoltage");
    unmapped_read_a: assert property ($past(i_reg_rd) && $past(i_reg_addr) != 8'h02
        && $past(i_reg_addr) != 8'h09 |-> o_reg_rdata == 8'h00)
        else $error("unmapped read gave nonzero data");
endmodule // lfm_fault_manager_assertions

bind lfm_fault_manager lfm_fault_manager_assertions #(
    .NUM_CH(NUM_CH), .STEP_CYCLES(STEP_CYCLES), .HOT_TMO_CYCLES(HOT_TMO_CYCLES)
) u_chk (
    .i_sys_clk(i_sys_clk), .i_rst_n(i_rst_n), .i_fet_fully_on(i_fet_fully_on),
    .i_input_undervoltage_lockout(i_input_undervoltage_lockout),
    .i_switch_over_limit(i_switch_over_limit), .i_input_overcurrent(i_input_overcurrent),
    .i_ovp_above_collapse(i_ovp_above_collapse), .i_reg_rd(i_reg_rd),
    .i_reg_addr(i_reg_addr), .o_reg_rdata(o_reg_rdata), .o_boost_run(o_boost_run),
    .o_switch_on(o_switch_on), .o_current_limit(o_current_limit),
    .o_fet_gate_off(o_fet_gate_off), .o_channel_enable(o_channel_enable)
);

//--- verif/lfm_led_partner.sv
// Model of the LED strings and the input protection FET around the driver.
// Assumes the bench commands opens and shorts; outputs change at falling edges.
`timescale 1ns/1ps

module lfm_led_partner #(
    parameter FET_ON_CYCLES = 8
)(
    // Clock and reset.
    input  wire       i_sys_clk,
    input  wire       i_rst_n,
    // Scenario commands and driver state.
    input  wire [5:0] i_open_cmd,
    input  wire [5:0] i_short_cmd,
    input  wire [5:0] i_channel_enable,
    input  wire       i_boost_run,
    input  wire       i_fet_gate_off,
    // Comparator levels seen by the driver.
    output reg        o_fet_fully_on = 1'b0,
    output reg  [5:0] o_at_target = 6'h00,
    output reg  [5:0] o_sink_high = 6'h00
);
    reg [7:0] fet_cnt = 8'h00;

    // The FET enhances slowly and drops when commanded off; strings conduct only when powered.
    always @(negedge i_sys_clk)
    begin
        fet_cnt <= (!i_rst_n || i_fet_gate_off) ? 8'h00 : fet_cnt + {7'h0, fet_cnt != 8'hFF};
        o_fet_fully_on <= (fet_cnt >= FET_ON_CYCLES) && !i_fet_gate_off;
        o_at_target <= i_channel_enable & ~i_open_cmd & {6{i_boost_run}};
        o_sink_high <= i_short_cmd & i_channel_enable;
    end
endmodule // lfm_led_partner

//--- verif/tb_top.sv
// Self-checking bench for the LED driver fault manager.
// Assumes the design under verilog/ and the partner model beside this file.
`timescale 1ns/1ps
`include "lfm_consts.vh"
`define CHK(nm, exp, got) begin checks = checks + 1; if ((got) !== (exp)) begin \
    fails = fails + 1; $display("ERROR %s expected %0h seen %0h", nm, exp, got); end end

module tb_top;
    localparam STEP = 20;
    localparam HOT = 10;
    reg        sys_clk = 1'b0, rst_n = 1'b0, input_undervoltage_lockout = 1'b0, over = 1'b0, ovc = 1'b0;
    reg        coll = 1'b0, hot = 1'b0, stable = 1'b1, swst = 1'b0, dim = 1'b0, ext = 1'b0;
    reg        wr = 1'b0, rd = 1'b0, output_overvoltage_sense = 1'b0;
    reg  [7:0] addr = 8'h00, wdata = 8'h00, rdv;
    reg  [5:0] open_cmd = 6'h00, short_cmd = 6'h00;
    integer    fails = 0, checks = 0, cyc = 0;
    wire       fet_on, run, sw_on, gate_off;
    wire [3:0] lim;
    wire [5:0] at_tgt, sink_hi, en;
    wire [7:0] rdata;

    // ****************************************
    // Clock, timing strobes and hang guard
    // ****************************************
    initial forever #5 sys_clk = ~sys_clk;
    always @(negedge sys_clk)
    begin
        swst <= (cyc % 8 == 0);
        dim <= (cyc % 10 == 0);
    end
    always @(posedge sys_clk)
    begin
        cyc = cyc + 1;
        if (cyc == 3000)
        begin
            fails = fails + 1;
            give_verdict;
        end
    end

    lfm_led_partner u_leds (.i_sys_clk(sys_clk), .i_rst_n(rst_n), .i_open_cmd(open_cmd),
        .i_short_cmd(short_cmd), .i_channel_enable(en), .i_boost_run(run),
        .i_fet_gate_off(gate_off), .o_fet_fully_on(fet_on), .o_at_target(at_tgt),
        .o_sink_high(sink_hi));
    lfm_fault_manager #(.NUM_CH(6), .STEP_CYCLES(STEP), .HOT_TMO_CYCLES(HOT)) dut (
        .i_sys_clk(sys_clk), .i_rst_n(rst_n), .i_fet_fully_on(fet_on),
        .i_input_undervoltage_lockout(input_undervoltage_lockout), .i_switch_over_limit(over),
        .i_input_overcurrent(ovc), .i_output_overvoltage_sense(output_overvoltage_sense),
        .i_ovp_above_collapse(coll), .i_temp_above_lower(hot), .i_loop_stable(stable),
        .i_led_sink_channel_at_target(at_tgt), .i_channel_short_guard(sink_hi),
        .i_sw_cycle_start(swst), .i_dim_cycle_tick(dim), .i_ramp_extend(ext),
        .i_reg_wr(wr), .i_reg_rd(rd), .i_reg_addr(addr), .i_reg_wdata(wdata),
        .o_reg_rdata(rdata), .o_boost_run(run), .o_switch_on(sw_on),
        .o_current_limit(lim), .o_fet_gate_off(gate_off), .o_channel_enable(en));

    // Waits a number of falling edges.
    task wait_cyc(input integer n);
        repeat (n) @(negedge sys_clk);
    endtask

    // Writes one register byte in a single strobe cycle.
    task reg_write(input [7:0] a, input [7:0] d);
    begin
        @(negedge sys_clk);
        wr = 1'b1;
        addr = a;
        wdata = d;
        @(negedge sys_clk);
        wr = 1'b0;
    end
    endtask

    // Reads one register byte; data is registered one cycle after the strobe.
    task reg_read(input [7:0] a, output [7:0] d);
    begin
        @(negedge sys_clk);
        rd = 1'b1;
        addr = a;
        @(negedge sys_clk);
        rd = 1'b0;
        d = rdata;
    end
    endtask

    // Prints the counts and the verdict, then ends the run.
    task give_verdict;
    begin
        $display("Comparisons %0d, mismatches %0d", checks, fails);
        if (fails == 0 && checks > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    end
    endtask

    // ****************************************
    // Main sequence
    // ****************************************
    initial
    begin
        wait_cyc(5);
        rst_n = 1'b1;
        `CHK("limit", 4'h1, lim)
        `CHK("enable", 6'h3F, en)
        `CHK("gate_off", 1'b0, gate_off)
        reg_write(`LFM_REG_OUTPUT_MASK, 8'h01);
        open_cmd = 6'h01;
        wait_cyc(4);
        `CHK("boost_run", 1'b0, run)
        wait_cyc(12);
        `CHK("boost_run", 1'b1, run)
        ext = 1'b1;
        wait_cyc(30);
        ext = 1'b0;
        wait_cyc(7 * STEP - 25);
        `CHK("ramp_open", 1'b1, lim < 4'h8)
        wait_cyc(40);
        `CHK("limit", 4'h8, lim)
        over = 1'b1;
        wait_cyc(5);
        `CHK("switch", 1'b0, sw_on)
        over = 1'b0;
        reg_read(`LFM_REG_OUTPUT_MASK, rdv);
        `CHK("mask", 8'h01, rdv)
        reg_write(`LFM_REG_FAULT_STATUS, 8'hFF);
        reg_read(`LFM_REG_FAULT_STATUS, rdv);
        `CHK("status", 8'h00, rdv)
        reg_read(8'h05, rdv);
        `CHK("unmapped", 8'h00, rdv)
        `CHK("enable", 6'h3E, en)
        stable = 1'b0;
        open_cmd = 6'h03;
        wait_cyc(100);
        `CHK("en1", 1'b1, en[1])
        stable = 1'b1;
        wait_cyc(30);
        `CHK("en1", 1'b1, en[1])
        wait_cyc(50);
        `CHK("en1", 1'b0, en[1])
        reg_read(`LFM_REG_FAULT_STATUS, rdv);
        `CHK("status", 8'h02, rdv)
        short_cmd = 6'h04;
        wait_cyc(30);
        `CHK("en2", 1'b1, en[2])
        wait_cyc(50);
        `CHK("en2", 1'b0, en[2])
        hot = 1'b1;
        open_cmd = 6'h0B;
        wait_cyc(4);
        `CHK("en3", 1'b1, en[3])
        wait_cyc(16);
        `CHK("en3", 1'b0, en[3])
        reg_read(`LFM_REG_FAULT_STATUS, rdv);
        `CHK("status", 8'h0E, rdv)
        coll = 1'b1;
        wait_cyc(5);
        `CHK("gate_off", 1'b0, gate_off)
        coll = 1'b0;
        wait_cyc(5);
        `CHK("gate_off", 1'b1, gate_off)
        ovc = 1'b1;
        wait_cyc(5);
        ovc = 1'b0;
        wait_cyc(5);
        `CHK("enable", 6'h00, en)
        input_undervoltage_lockout = 1'b1;
        wait_cyc(5);
        `CHK("boost_run", 1'b0, run)
        `CHK("limit", 4'h1, lim)
        input_undervoltage_lockout = 1'b0;
        wait_cyc(20);
        `CHK("boost_run", 1'b0, run)
        hot = 1'b0;
        rst_n = 1'b0;
        wait_cyc(5);
        rst_n = 1'b1;
        reg_read(`LFM_REG_FAULT_STATUS, rdv);
        `CHK("status", 8'h00, rdv)
        wait_cyc(150);
        `CHK("en0", 1'b1, en[0])
        output_overvoltage_sense = 1'b1;
        wait_cyc(80);
        `CHK("en0", 1'b0, en[0])
        `CHK("en4", 1'b1, en[4])
        give_verdict;
    end
endmodule // tb_top

//--- verilog/lfm_channel_guard.v
// One LED sink channel's classifier: good/open tracking, short guard and
// open time-out, disabling the channel and latching its fault.
// Assumes comparator inputs are already synchronised to i_sys_clk.
`timescale 1ns/1ps
`include "lfm_consts.vh"

module lfm_channel_guard #(
    parameter HOT_TMO_CYCLES = `LFM_HOT_TMO_CYCLES
)(
    // Clock and reset.
    input  wire i_sys_clk,
    input  wire i_rst_n,
    // Channel conditions.
    input  wire i_active,
    input  wire i_at_target,
    input  wire i_sink_high,
    input  wire i_stable,
    input  wire i_force_open,
    input  wire i_hot,
    input  wire i_dim_tick,
    // Channel result.
    output reg  o_enable,
    output reg  o_fault
);

    // ************************************************************
    // Classification and time-out
    // ************************************************************

    reg        good;
    reg        open_det;
    reg [2:0]  dim_cnt;
    reg [31:0] hot_cnt;

    // Tracks good and open, then counts the time-out before disabling.
    always @(posedge i_sys_clk)
    begin
        if (!i_rst_n)
        begin
            good     <= 1'b0;
            open_det <= 1'b0;
            dim_cnt  <= 3'h0;
            hot_cnt  <= 32'h0;
            o_enable <= 1'b1;
            o_fault  <= 1'b0;
        end
        else if (!i_active || !o_enable)
        begin
            dim_cnt <= 3'h0;
            hot_cnt <= 32'h0;
        end
        else
        begin
            if (i_at_target)
                good <= 1'b1;
            if ((good && !i_at_target && i_stable) ||
                (i_force_open && !good))
                open_det <= 1'b1;
            if ((open_det || i_sink_high) && i_stable)
            begin
                if (i_hot && open_det)
                begin
                    if (hot_cnt >= HOT_TMO_CYCLES - 1)
                    begin
                        o_enable <= 1'b0;
                        o_fault  <= 1'b1;
                    end
                    hot_cnt <= hot_cnt + 32'h1;
                end
                else if (i_dim_tick)
                begin
                    if (dim_cnt == `LFM_DIM_TIMEOUTS - 1)
                    begin
                        o_enable <= 1'b0;
                        o_fault  <= 1'b1;
                    end
                    dim_cnt <= dim_cnt + 3'h1;
                end
            end
            else
            begin
                dim_cnt <= 3'h0;
                hot_cnt <= 32'h0;
            end
        end
    end

endmodule // lfm_channel_guard

//--- verilog/lfm_consts.vh
// Constants for the LED driver fault manager: register offsets, reset values,
// soft-start steps and timing counts.
// Assumes a 100 MHz system clock.
`ifndef LFM_CONSTS_VH
`define LFM_CONSTS_VH

// Register offsets on the serial management port.
`define LFM_REG_FAULT_STATUS  8'h02
`define LFM_REG_OUTPUT_MASK   8'h09

// Reset values.
`define LFM_MASK_RESET        8'h00
`define LFM_STATUS_RESET      8'h00

// Soft-start current limit, in 275 mA units: first level and final level.
`define LFM_ILIM_STEP_MA      275
`define LFM_ILIM_FIRST        4'h1
`define LFM_ILIM_FINAL        4'h8

// Clock rate and times.
`define LFM_CLK_MHZ           100
`define LFM_RAMP_MIN_US       8000
`define LFM_STEP_MIN_US       1000
`define LFM_STEP_CYCLES       ((`LFM_STEP_MIN_US) * (`LFM_CLK_MHZ))
`define LFM_HOT_TMO_US        800
`define LFM_HOT_TMO_CYCLES    ((`LFM_HOT_TMO_US) * (`LFM_CLK_MHZ))
`define LFM_DIM_TIMEOUTS      6

// Fraction of the overvoltage level that marks a collapse, in percent.
`define LFM_OVP_COLLAPSE_PCT  20

`endif

//--- verilog/lfm_fault_manager.v
// LED driver fault manager: inrush gating, soft-start current limit,
// cycle-by-cycle switch limit, channel fault classification and the
// fault status and output mask registers.
// Assumes analog comparator inputs arrive asynchronously and that a serial
// management front end presents simple register read/write strobes.
// The hot time-out and ramp steps are counted in
// clock cycles and set by parameters.
// No state survives reset; the mask
// starts clear so all channels run.
//
// Behaviour
// - Boost idle until protection FET fully on.
// - Current limit starts lowest, seven equal steps.
// - Ramp spans at least minimum time, extendable; the default ramp is seven 1000 us steps, 7000 us, under the 8000 us minimum.
// - Switch on-time ends when current exceeds limit.
// - Input overcurrent fault shuts all channels.
// - Transients never let channel faults disable channels.
// - Channel faults recorded in fault status register.
// - Output mask register set only by host writes.
// - Host masks channels; only unmasked faults reported.
// - Channel above short threshold gets disabled.
// - Channel reaching target current marked good.
// - Good channel dropping below target becomes open.
// - Overvoltage or warm die: non-good channels open.
// - Open channel disabled only after time-out.
// - Time-out shortened above lower temperature threshold.
// - Zener-bypassed channel stays on unless overvoltage.
// - Overvoltage rise then collapse turns FET off.
// - Undervoltage stops switching until supply returns.
// - Hot time-out lasts HOT_TMO_CYCLES cycles, 800 us by default.
// - Normal short time-out is six dimming cycles.
`timescale 1ns/1ps
`include "lfm_consts.vh"

module lfm_fault_manager #(
    parameter NUM_CH          = 6,
    parameter STEP_CYCLES     = `LFM_STEP_CYCLES,
    parameter HOT_TMO_CYCLES  = `LFM_HOT_TMO_CYCLES
)(
    // Clock and reset.
    input  wire              i_sys_clk,
    input  wire              i_rst_n,
    // Analog comparator inputs, asynchronous.
    input  wire              i_fet_fully_on,
    input  wire              i_input_undervoltage_lockout,
    input  wire              i_switch_over_limit,
    input  wire              i_input_overcurrent,
    input  wire              i_output_overvoltage_sense,
    input  wire              i_ovp_above_collapse,
    input  wire              i_temp_above_lower,
    input  wire              i_loop_stable,
    input  wire [NUM_CH-1:0] i_led_sink_channel_at_target,
    input  wire [NUM_CH-1:0] i_channel_short_guard,
    // Timing inputs from the converter and dimming logic, same clock.
    input  wire              i_sw_cycle_start,
    input  wire              i_dim_cycle_tick,
    input  wire              i_ramp_extend,
    // Register access strobes from the serial front end, same clock.
    input  wire              i_reg_wr,
    input  wire              i_reg_rd,
    input  wire [7:0]        i_reg_addr,
    input  wire [7:0]        i_reg_wdata,
    output reg  [7:0]        o_reg_rdata,
    // Converter and channel controls.
    output reg               o_boost_run,
    output reg               o_switch_on,
    output reg  [3:0]        o_current_limit,
    output reg               o_fet_gate_off,
    output wire [NUM_CH-1:0] o_channel_enable
);

    // ************************************************************
    // Input synchronisers
    // ************************************************************

    localparam SW = 9 + 2 * NUM_CH;

    // Levels reach the logic two clocks late.
    // One chain keeps all inputs in step.
    // A pulse under one clock may be lost.
    // Reset clears both stages.

    reg [SW-1:0] sync_a;
    reg [SW-1:0] sync_b;

    // Two flops on every comparator input before any logic reads it.
    always @(posedge i_sys_clk)
    begin
        if (!i_rst_n)
        begin
            sync_a <= {SW{1'b0}};
            sync_b <= {SW{1'b0}};
        end
        else
        begin
            sync_a <= {i_fet_fully_on, i_input_undervoltage_lockout, i_switch_over_limit,
                       i_input_overcurrent, i_output_overvoltage_sense,
                       i_ovp_above_collapse, i_temp_above_lower, i_loop_stable,
                       1'b0, i_led_sink_channel_at_target, i_channel_short_guard};
            sync_b <= sync_a;
        end
    end

    wire              fet_on      = sync_b[SW-1];
    wire              input_undervoltage_lockout        = sync_b[SW-2];
    wire              sw_over     = sync_b[SW-3];
    wire              in_ocp      = sync_b[SW-4];
    wire              output_overvoltage_sense         = sync_b[SW-5];
    wire              ovp_above   = sync_b[SW-6];
    wire              temp_warm   = sync_b[SW-7];
    wire              stable      = sync_b[SW-8];
    wire [NUM_CH-1:0] at_target   = sync_b[2*NUM_CH-1:NUM_CH];
    wire [NUM_CH-1:0] sink_high   = sync_b[NUM_CH-1:0];
    // The spare chain bit is never read;
    // it pads the chain to a fixed width.

    // ************************************************************
    // Start-up sequencer
    // ************************************************************

    // One-hot states; an illegal code falls
    // back to waiting for the FET.
    // The ramp state ends after seven steps.
    localparam ST_WAIT = 3'b001;
    localparam ST_RAMP = 3'b010;
    localparam ST_RUN  = 3'b100;

    reg [2:0]  state;
    reg [31:0] step_cnt;
    reg        ch_reset;

    // ch_reset clears every channel guard
    // whenever the start-up restarts, so
    // stale good marks never carry over.
    // Undervoltage sends the limit back to
    // the first level and restarts the wait.

    // Waits for the FET, then steps the limit up one level per step period.
    always @(posedge i_sys_clk)
    begin
        if (!i_rst_n)
        begin
            state           <= ST_WAIT;
            step_cnt        <= 32'h0;
            o_boost_run     <= 1'b0;
            o_current_limit <= `LFM_ILIM_FIRST;
            ch_reset        <= 1'b1;
        end
        else if (input_undervoltage_lockout)
        begin
            // Undervoltage: stop switching and restart from the beginning.
            state           <= ST_WAIT;
            step_cnt        <= 32'h0;
            o_boost_run     <= 1'b0;
            o_current_limit <= `LFM_ILIM_FIRST;
            ch_reset        <= 1'b1;
        end
        else
        begin
            ch_reset <= 1'b0;
            case (state)
                ST_WAIT:
                begin
                    o_current_limit <= `LFM_ILIM_FIRST;
                    if (fet_on)
                    begin
                        o_boost_run <= 1'b1;
                        state       <= ST_RAMP;
                    end
                end
                ST_RAMP:
                begin
                    // Extension holds the count so low-duty dimming lengthens it.
                    if (!i_ramp_extend)
                    begin
                        if (step_cnt >= STEP_CYCLES - 1)
                        begin
                            step_cnt        <= 32'h0;
                            o_current_limit <= o_current_limit + 4'h1;
                            if (o_current_limit == `LFM_ILIM_FINAL - 4'h1)
                                state <= ST_RUN;
                        end
                        else
                            step_cnt <= step_cnt + 32'h1;
                    end
                end
                ST_RUN:
                    o_current_limit <= `LFM_ILIM_FINAL;
                default:
                    state <= ST_WAIT;
            endcase
        end
    end

    // ************************************************************
    // Cycle-by-cycle switch limit
    // ************************************************************

    // The over-limit level wins over a cycle
    // start, so a switch held above the limit
    // never turns back on in the same cycle.
    // Losing the run enable drops it at once.
    // Switch turns on at each cycle start and ends once current exceeds the limit.
    always @(posedge i_sys_clk)
    begin
        if (!i_rst_n)
            o_switch_on <= 1'b0;
        else if (!o_boost_run || sw_over)
            o_switch_on <= 1'b0;
        else if (i_sw_cycle_start)
            o_switch_on <= 1'b1;
    end

    // ************************************************************
    // Overvoltage collapse and input overcurrent
    // ************************************************************

    reg ovp_armed;
    reg ocp_shutdown;

    // Both events latch until reset: the FET
    // stays off and channels stay shut, so a
    // fault cannot restart the converter.
    // Arming needs the sense above the
    // collapse level at least once first.
    // Rise above then fall below the collapse fraction switches the FET off.
    always @(posedge i_sys_clk)
    begin
        if (!i_rst_n)
        begin
            ovp_armed      <= 1'b0;
            o_fet_gate_off <= 1'b0;
            ocp_shutdown   <= 1'b0;
        end
        else
        begin
            if (ovp_above)
                ovp_armed <= 1'b1;
            else if (ovp_armed)
                o_fet_gate_off <= 1'b1;
            if (in_ocp)
                ocp_shutdown <= 1'b1;
        end
    end

    // ************************************************************
    // Output mask register
    // ************************************************************

    reg [7:0] output_mask;

    // Bits above the channel count are kept
    // for read-back only and drive nothing.
    // Writes to any other offset are dropped.
    // A set bit also hides status reports.
    // Host writes the mask, set bits disable and hide a channel.
    always @(posedge i_sys_clk)
    begin
        if (!i_rst_n)
            output_mask <= `LFM_MASK_RESET;
        else if (i_reg_wr && i_reg_addr == `LFM_REG_OUTPUT_MASK)
            output_mask <= i_reg_wdata;
    end

    // ************************************************************
    // Channel guards
    // ************************************************************

    wire [NUM_CH-1:0] ch_en;
    wire [NUM_CH-1:0] ch_fault;
    wire              force_open = output_overvoltage_sense | temp_warm;

    // A masked channel is held inactive, so it
    // never counts a time-out or sets a fault.
    // Overvoltage or a warm die forces every
    // channel that is not yet good to open.
    // The short guard uses dim-tick time-outs
    // even while hot; only opens speed up.

    genvar g;
    generate
        for (g = 0; g < NUM_CH; g = g + 1)
        begin : g_ch
            lfm_channel_guard #(
                .HOT_TMO_CYCLES (HOT_TMO_CYCLES)
            ) u_guard (
                .i_sys_clk    (i_sys_clk),
                .i_rst_n      (i_rst_n & ~ch_reset),
                .i_active     (o_boost_run & ~output_mask[g]),
                .i_at_target  (at_target[g]),
                .i_sink_high  (sink_high[g]),
                .i_stable     (stable),
                .i_force_open (force_open),
                .i_hot        (temp_warm),
                .i_dim_tick   (i_dim_cycle_tick),
                .o_enable     (ch_en[g]),
                .o_fault      (ch_fault[g])
            );
        end
    endgenerate

    // Enables are gates of registers only,
    // so they never glitch on input noise.
    // Overcurrent shuts all channels at once.
    // Channels run only when enabled, unmasked and no input overcurrent.
    assign o_channel_enable = ch_en & ~output_mask[NUM_CH-1:0]
                              & {NUM_CH{~ocp_shutdown}};

    // ************************************************************
    // Fault status register
    // ************************************************************

    // Bits stay set across undervoltage
    // restarts; only reset clears them, so
    // the host can read a fault much later.
    reg  [NUM_CH-1:0] fault_status;
    wire [7:0]        status_reset = `LFM_STATUS_RESET;

    // Sticky per-channel faults; masked channels never report.
    always @(posedge i_sys_clk)
    begin
        if (!i_rst_n)
            fault_status <= status_reset[NUM_CH-1:0];
        else
            fault_status <= fault_status | (ch_fault & ~output_mask[NUM_CH-1:0]);
    end

    // Read data holds until the next read,
    // so a slow host may take it late.
    // Status bits above the channels read 0.
    // Reads have no side effects.
    // Registered read data, unmapped offsets read zero.
    always @(posedge i_sys_clk)
    begin
        if (!i_rst_n)
            o_reg_rdata <= 8'h00;
        else if (i_reg_rd)
        begin
            case (i_reg_addr)
                `LFM_REG_FAULT_STATUS: o_reg_rdata <= {{(8-NUM_CH){1'b0}}, fault_status};
                `LFM_REG_OUTPUT_MASK:  o_reg_rdata <= output_mask;
                default:               o_reg_rdata <= 8'h00;
            endcase
        end
    end

endmodule // lfm_fault_manager
